// ==== hdl/ise_bank.sv ====
// Top of the interrupt enable bank: register port, storage, enable outputs
//
// Local design decision: the strobed register port.
`default_nettype none
// Operation
// RL1 - Writing one to set bit enables interrupt
// RL2 - Writing zero to set bit changes nothing
// RL3 - Read returns current enable state per bit
// RL4 - Low word irqs 0-31, high word next
// RL5 - Low word: port0, port1 pins, port2 low
// RL6 - High bits 0-7: port2 high, port3 pins
// RL7 - High bits 8-19: peripheral interrupts in order
// RL8 - High bits 21-24: GPIO ports 3,2,1,0
// RL9 - Software avoids ones in reserved bits
// RL10 - Software disables only through clear registers
// RL11 - Writing one to clear bit disables interrupt
// RL12 - One shared bit each, cleared at reset
module ise_bank
    import ise_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    output logic [11:0] wake_pin_p0_enable,
    output logic [11:0] wake_pin_p1_enable,
    output logic [11:0] wake_pin_p2_enable,
    output logic [3:0] wake_pin_p3_enable,
    output logic i2c_irq_enable,
    output logic [1:0] timer16_irq_enable,
    output logic [1:0] timer32_irq_enable,
    output logic sync_serial_irq_enable,
    output logic uart_irq_enable,
    output logic usb_main_irq_enable,
    output logic usb_fast_irq_enable,
    output logic adc_irq_enable,
    output logic watchdog_irq_enable,
    output logic brownout_irq_enable,
    output logic [3:0] gpio_port_irq_enable
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    // Limitation: the bank stays in reset for two edges after rst_n
    // rises, so software must hold off its first access until then.
    // Every flop of the bank but the two sync stages, read port included, sits behind this copy.
    logic rst_meta_q;
    logic rst_meta_d;
    logic rst_sync_q;
    logic rst_sync_d;

    // Constant high walks in behind the released reset
    always_comb begin
        rst_meta_d = 1'b1;
        rst_sync_d = rst_meta_q;
    end

    // Two stages so release never lands mid-edge in the bank
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= rst_meta_d;
            rst_sync_q <= rst_sync_d;
        end
    end

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Every address bit is compared: four wide comparators, but no
    // other address can alias onto the bank.
    logic hit_set_lo;
    logic hit_set_hi;
    logic hit_clr_lo;
    logic hit_clr_hi;
    logic hit_lo;
    logic hit_hi;
    logic set_lo_we;
    logic set_hi_we;
    logic clr_lo_we;
    logic clr_hi_we;
    logic [31:0] en_lo;
    logic [31:0] en_hi;

    // Word hits, shared by the write and read paths
    always_comb begin
        hit_set_lo = (addr == ISE_SET_LOW_ADDR);
        hit_set_hi = (addr == ISE_SET_HIGH_ADDR);
        hit_clr_lo = (addr == ISE_CLR_LOW_ADDR);
        hit_clr_hi = (addr == ISE_CLR_HIGH_ADDR);
    end

    // Set and clear views of one word read the same storage
    always_comb begin
        hit_lo = hit_set_lo || hit_clr_lo;
        hit_hi = hit_set_hi || hit_clr_hi;
    end

    // ------------------------------------------------------------
    // Write strobes
    // ------------------------------------------------------------
    // RL4 word selects group
    always_comb begin
        set_lo_we = wr_en && hit_set_lo;
        set_hi_we = wr_en && hit_set_hi;
        clr_lo_we = wr_en && hit_clr_lo;
        clr_hi_we = wr_en && hit_clr_hi;
    end

    // ------------------------------------------------------------
    // Enable storage, interrupts 0-31 and 32-63
    // ------------------------------------------------------------
    // Reserved high bits get no flop: a stray one written there is
    // dropped, and the read mask keeps them zero as well.
    // Set and clear views sit at different addresses, so one write
    // never asks for both at once.

    // RL4 low word first
    ise_enable_word #(
        .IMPL_MASK(ISE_LO_IMPL_MASK)
    ) u_word_lo (
        .clk(clk),
        .rst_n(rst_sync_q),
        .set_we(set_lo_we),
        .clr_we(clr_lo_we),
        .wdata(wdata),
        .en_q(en_lo)
    );

    // RL4 high word next
    ise_enable_word #(
        .IMPL_MASK(ISE_HI_IMPL_MASK)
    ) u_word_hi (
        .clk(clk),
        .rst_n(rst_sync_q),
        .set_we(set_hi_we),
        .clr_we(clr_hi_we),
        .wdata(wdata),
        .en_q(en_hi)
    );

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    // Read data are a registered copy, so a read issued right after
    // a write already sees the written enables.
    logic [31:0] rd_lo_word;
    logic [31:0] rd_hi_word;
    logic [31:0] rdata_d;

    // RL9 reserved read zero
    always_comb begin
        rd_lo_word = en_lo & ISE_LO_IMPL_MASK;
        rd_hi_word = en_hi & ISE_HI_IMPL_MASK;
    end

    // Both views read the same state; unmapped reads give zero
    always_comb begin
        rdata_d = ISE_RDATA_RESET;
        if (rd_en) begin
            // RL3 read enable state
            if (hit_lo) begin
                rdata_d = rd_lo_word;
            end else if (hit_hi) begin
                rdata_d = rd_hi_word;
            end
        end
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            rdata <= ISE_RDATA_RESET;
        end else begin
            rdata <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Wake-up pin enables toward the start logic
    // ------------------------------------------------------------
    // Outputs are the storage flops, renamed by field: no extra stage,
    // so an enable follows its write by exactly one edge.

    // RL5 port 0 pins
    always_comb begin
        wake_pin_p0_enable = en_lo[ISE_LO_P0_LSB +: 12];
    end

    // RL5 port 1 pins
    always_comb begin
        wake_pin_p1_enable = en_lo[ISE_LO_P1_LSB +: 12];
    end

    // RL6 port 2 split
    // Pins 0-7 live in the low word, pins 8-11 in the high word
    always_comb begin
        wake_pin_p2_enable = {en_hi[ISE_HI_P2HI_LSB +: 4],
                              en_lo[ISE_LO_P2_LSB +: 8]};
    end

    // RL6 port 3 pins
    always_comb begin
        wake_pin_p3_enable = en_hi[ISE_HI_P3_LSB +: 4];
    end

    // ------------------------------------------------------------
    // Peripheral enables, high word bits 8 to 14
    // ------------------------------------------------------------
    // RL7 serial bus first
    always_comb begin
        i2c_irq_enable = en_hi[ISE_HI_I2C_BIT];
    end

    // RL7 16-bit timer pair
    // Index 0 is the first timer of the pair
    always_comb begin
        timer16_irq_enable = en_hi[ISE_HI_I2C_BIT + 1 +: 2];
    end

    // RL7 32-bit timer pair
    // Index 0 is the first timer of the pair
    always_comb begin
        timer32_irq_enable = en_hi[ISE_HI_I2C_BIT + 3 +: 2];
    end

    // RL7 synchronous serial port
    always_comb begin
        sync_serial_irq_enable = en_hi[ISE_HI_I2C_BIT + 5];
    end

    // RL7 UART
    always_comb begin
        uart_irq_enable = en_hi[ISE_HI_I2C_BIT + 6];
    end

    // ------------------------------------------------------------
    // Peripheral enables, high word bits 15 to 19
    // ------------------------------------------------------------
    // RL7 USB main line
    always_comb begin
        usb_main_irq_enable = en_hi[ISE_HI_I2C_BIT + 7];
    end

    // RL7 USB fast line
    // Separate bit so the fast path can stay on alone
    always_comb begin
        usb_fast_irq_enable = en_hi[ISE_HI_I2C_BIT + 8];
    end

    // RL7 analog converter
    always_comb begin
        adc_irq_enable = en_hi[ISE_HI_I2C_BIT + 9];
    end

    // RL7 watchdog
    always_comb begin
        watchdog_irq_enable = en_hi[ISE_HI_I2C_BIT + 10];
    end

    // RL7 brown-out, last peripheral
    always_comb begin
        brownout_irq_enable = en_hi[ISE_HI_BOD_BIT];
    end

    // ------------------------------------------------------------
    // Whole-port GPIO enables, high word bits 21 to 24
    // ------------------------------------------------------------
    // A port's enable gates its combined pin interrupt only; the
    // per-pin wake-up enables above are separate bits.

    // RL8 GPIO ports reversed
    // Index n is port n; the register places port 3 lowest
    for (genvar gi = 0; gi < 4; gi++) begin : g_gpio
        always_comb begin
            gpio_port_irq_enable[gi] = en_hi[ISE_HI_GPIO0_BIT - gi];
        end
    end
endmodule
`default_nettype wire

// ==== hdl/ise_enable_word.sv ====
// One 32-bit word of shared enable storage with set and clear views
`default_nettype none
module ise_enable_word
    import ise_pkg::*;
#(
    parameter logic [31:0] IMPL_MASK = 32'hffffffff
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic set_we,
    input wire logic clr_we,
    input wire logic [31:0] wdata,
    output logic [31:0] en_q
);
    logic [31:0] en_d;

    // ------------------------------------------------------------
    // Per-bit enable storage
    // ------------------------------------------------------------
    // RL12 one bit shared
    genvar gi;
    for (gi = 0; gi < ISE_WORD_W; gi++) begin : g_bit
        if (IMPL_MASK[gi]) begin : g_impl
            // Set and clear come from different strobes, never together
            always_comb begin
                en_d[gi] = en_q[gi];
                // RL1 one sets enable
                // RL2 zero leaves bit
                if (set_we && wdata[gi]) begin
                    en_d[gi] = 1'b1;
                // RL11 one clears enable
                end else if (clr_we && wdata[gi]) begin
                    en_d[gi] = 1'b0;
                end
            end
            // RL12 reset clears all
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    en_q[gi] <= ISE_EN_RESET[gi];
                end else begin
                    en_q[gi] <= en_d[gi];
                end
            end
        end else begin : g_rsvd
            // RL9 reserved bits hold zero
            assign en_d[gi] = 1'b0;
            assign en_q[gi] = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== hdl/ise_pkg.sv ====
// Package: register map, field layout and reset values of the enable bank
`default_nettype none
package ise_pkg;
    // Register word addresses, as printed (byte addresses)
    localparam logic [31:0] ISE_SET_LOW_ADDR = 32'he000e100;
    localparam logic [31:0] ISE_SET_HIGH_ADDR = 32'he000e104;
    localparam logic [31:0] ISE_CLR_LOW_ADDR = 32'he000e180;
    localparam logic [31:0] ISE_CLR_HIGH_ADDR = 32'he000e184;
    // Bank geometry
    localparam int ISE_NUM_IRQ = 64;
    localparam int ISE_WORD_W = 32;
    // Low word field positions
    localparam int ISE_LO_P0_LSB = 0;
    localparam int ISE_LO_P1_LSB = 12;
    localparam int ISE_LO_P2_LSB = 24;
    // High word field positions
    localparam int ISE_HI_P2HI_LSB = 0;
    localparam int ISE_HI_P3_LSB = 4;
    localparam int ISE_HI_I2C_BIT = 8;
    localparam int ISE_HI_BOD_BIT = 19;
    localparam int ISE_HI_RSVD_BIT = 20;
    localparam int ISE_HI_GPIO3_BIT = 21;
    localparam int ISE_HI_GPIO0_BIT = 24;
    // Implemented bits of the high word: 19:0 and 24:21
    localparam logic [31:0] ISE_HI_IMPL_MASK = 32'h01efffff;
    localparam logic [31:0] ISE_LO_IMPL_MASK = 32'hffffffff;
    // Reset values
    localparam logic [31:0] ISE_EN_RESET = 32'h00000000;
    localparam logic [31:0] ISE_RDATA_RESET = 32'h00000000;
endpackage
`default_nettype wire

// ==== test/ise_bank_monitor.sv ====
// Checker: register port against enable output relations
`default_nettype none
module ise_bank_monitor
    import ise_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [31:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] rdata,
    input wire logic [11:0] wake_pin_p0_enable,
    input wire logic [11:0] wake_pin_p2_enable,
    input wire logic brownout_irq_enable,
    input wire logic [3:0] gpio_port_irq_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Write and read relations
    // ----------------------------------------
    AST_SET_P0: assert property (
        wr_en && addr == ISE_SET_LOW_ADDR && wdata[0] |=> wake_pin_p0_enable[0])
        else $error("set of low bit 0 not taken");
    AST_HOLD_P0: assert property (
        wake_pin_p0_enable[0] && !(wr_en && addr == ISE_CLR_LOW_ADDR)
        |=> wake_pin_p0_enable[0]) else $error("enable lost without clear");
    AST_CLR_P0: assert property (
        wr_en && addr == ISE_CLR_LOW_ADDR && wdata[0] |=> !wake_pin_p0_enable[0])
        else $error("clear of low bit 0 not taken");
    AST_SET_P2HI: assert property (
        wr_en && addr == ISE_SET_HIGH_ADDR && wdata[0] |=> wake_pin_p2_enable[8])
        else $error("set of high bit 0 not taken");
    AST_SET_BROWN: assert property (
        wr_en && addr == ISE_SET_HIGH_ADDR && wdata[19] |=> brownout_irq_enable)
        else $error("set of high bit 19 not taken");
    AST_RD_LOW: assert property (
        rd_en && addr == ISE_SET_LOW_ADDR |=> rdata[11:0] == wake_pin_p0_enable)
        else $error("low read differs from enables");
    AST_RD_GPIO: assert property (
        rd_en && addr == ISE_SET_HIGH_ADDR |=> rdata[31:25] == 7'h0 &&
        gpio_port_irq_enable == {rdata[21], rdata[22], rdata[23], rdata[24]})
        else $error("high read differs from port enables");
    AST_RD_IDLE: assert property (
        !$past(rd_en) |-> rdata == 32'h0) else $error("read data outside slot");
endmodule
bind ise_bank ise_bank_monitor mon (.clk, .rst_n, .addr, .wdata, .wr_en,
    .rd_en, .rdata, .wake_pin_p0_enable, .wake_pin_p2_enable,
    .brownout_irq_enable, .gpio_port_irq_enable);
`default_nettype wire

// ==== test/ise_sw_model.sv ====
// Software side model: register master of the enable bank
`default_nettype none
module ise_sw_model
    import ise_pkg::*;
(
    input wire logic clk,
    input wire logic [31:0] rdata,
    output logic wr_en,
    output logic rd_en,
    output logic [31:0] addr,
    output logic [31:0] wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {wr_en, rd_en, addr, wdata} = 66'h0;
    // One-cycle strobe; no wait states, so answer is in the next cycle
    task automatic acc(input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        wr_en <= w;
        rd_en <= !w;
        addr <= a;
        wdata <= (a == ISE_SET_HIGH_ADDR || a == ISE_CLR_HIGH_ADDR) ?
            d & ISE_HI_IMPL_MASK : d;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        // Read data stand until the next edge; take them there
        @(posedge clk);
        q = rdata;
    endtask
endmodule
`default_nettype wire

// ==== test/test_interrupt_set_enable_bank.sv ====
// Testbench: enable bank against a word level reference model
`default_nettype none
module test_interrupt_set_enable_bank;
    import ise_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr_en, rd_en, i2c, sync_serial_port, urt, usbm, usbf, adc, wdt, brownout_detector;
    logic [31:0] addr, wdata, rdata, lo, hi, q;
    logic [31:0] lo_ref = 32'h0;
    logic [31:0] hi_ref = 32'h0;
    logic [11:0] p0, p1, p2;
    logic [3:0] p3, gp;
    logic [1:0] t16, t32;
    int fail_count = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [31:0] adr [5] = '{ISE_SET_LOW_ADDR, ISE_SET_HIGH_ADDR,
        ISE_CLR_LOW_ADDR, ISE_CLR_HIGH_ADDR, 32'he000e108};
    always #10 clk = ~clk;
    ise_bank dut (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
        .wake_pin_p0_enable(p0), .wake_pin_p1_enable(p1),
        .wake_pin_p2_enable(p2), .wake_pin_p3_enable(p3),
        .i2c_irq_enable(i2c), .timer16_irq_enable(t16),
        .timer32_irq_enable(t32), .sync_serial_irq_enable(sync_serial_port),
        .uart_irq_enable(urt), .usb_main_irq_enable(usbm),
        .usb_fast_irq_enable(usbf), .adc_irq_enable(adc),
        .watchdog_irq_enable(wdt), .brownout_irq_enable(brownout_detector),
        .gpio_port_irq_enable(gp));
    ise_sw_model sw (.clk, .rdata, .wr_en, .rd_en, .addr, .wdata);
    // Enable lines gathered back into register word order
    assign lo = {p2[7:0], p1, p0};
    assign hi = {7'h0, gp[0], gp[1], gp[2], gp[3], 1'b0, brownout_detector, wdt, adc,
        usbf, usbm, urt, sync_serial_port, t32, t16, i2c, p3, p2[11:8]};
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic end_of_test;
        if (fail_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // One access, reference update, then every result compared
    task automatic op(input logic w, input logic [31:0] a,
        input logic [31:0] d);
        logic [31:0] e;
        sw.acc(w, a, d, q);
        e = 32'h0;
        if (w) case (a)
            ISE_SET_LOW_ADDR: lo_ref |= d;
            ISE_SET_HIGH_ADDR: hi_ref |= d & ISE_HI_IMPL_MASK;
            ISE_CLR_LOW_ADDR: lo_ref &= ~d;
            ISE_CLR_HIGH_ADDR: hi_ref &= ~d;
            default: ;
        endcase
        else if (a == adr[0] || a == adr[2]) e = lo_ref;
        else if (a == adr[1] || a == adr[3]) e = hi_ref;
        chk("read data", e, q);
        chk("low enables", lo_ref, lo);
        chk("high enables", hi_ref, hi);
    endtask
    // Hang guard, far above the expected run of about 950 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            end_of_test;
        end
    end
    initial begin
        void'($urandom(32'h3f10215b));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        op(1'b0, adr[0], 32'h0);
        op(1'b1, adr[0], 32'hffffffff);
        op(1'b1, adr[0], 32'h0);
        op(1'b1, adr[2], 32'h00000fff);
        op(1'b1, adr[1], 32'hffffffff);
        op(1'b0, adr[3], 32'h0);
        op(1'b1, adr[4], 32'hffffffff);
        op(1'b0, adr[4], 32'h0);
        op(1'b1, adr[3], 32'h00f00000);
        repeat (300) op(1'($urandom), adr[$urandom % 5], $urandom);
        // Reset in mid-run must drop every enable
        @(posedge clk) rst_n <= 1'b0;
        lo_ref = 32'h0;
        hi_ref = 32'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        op(1'b0, adr[1], 32'h0);
        end_of_test;
    end
endmodule
`default_nettype wire
